/* design/i2c_master_arbitration_brg.sv */
// Purpose: two-wire bus master sequencing with arbitration and baud timing
// Assumes: open-drain lines; *_OE_OUT high pulls the line low
// Notes: requests are one-cycle pulses taken only when idle
`timescale 1ns/1ps

// Overview of operation
// - released one-bit sampled low while SCL high flags collision, goes idle
// - collision in a byte stops shifting, clears buffer full, frees both lines
// - collision in start/restart/stop/ack aborts it and clears its busy bit
// - after collision, a seen stop condition sets the serial interrupt flag
// - new buffer write restarts the byte from its first bit
// - start with SDA or SCL already low aborts with collision
// - start: once SDA high, counter loads; SCL low meanwhile is collision
// - SDA low during first start count: reset counter, drive SDA low now
// - else SDA low at count end, count again, SCL low; no collision then
// - restart: free SDA, count, free SCL; SCL high then SDA low collides
// - restart count: SCL falling before SDA driven collides, SDA falling not
// - both high at time-out: SDA low, count again, then SCL low regardless
// - stop: SDA low, free SCL, count at SCL high, then SDA low collides
// - stop: SCL low after release, before SDA goes high, is collision
// - counter reloads from reload value and starts on buffer write
// - operation done: counter stops and SCL holds its last level
// - two reloads per SCL period; rate is fclk over four times reload+1
// - reset or port disable clears start seen and stop seen
module i2c_master_arbitration_brg #(
   parameter int RELOAD_W = i2c_arb_pkg::RELOAD_W
) (
   input wire logic CLK_IN,
   input wire logic RST_N_IN,
   input wire logic CE_IN,
   input wire logic PORT_EN_IN,
   input wire logic [RELOAD_W-1:0] RELOAD_IN,
   input wire logic START_REQ_IN,
   input wire logic RSTART_REQ_IN,
   input wire logic STOP_REQ_IN,
   input wire logic ACK_REQ_IN,
   input wire logic ACK_DATA_IN,
   input wire logic TX_WR_IN,
   input wire logic [7:0] TX_DATA_IN,
   input wire logic COLL_CLR_IN,
   input wire logic IRQ_CLR_IN,
   input wire logic SDA_IN,
   input wire logic SCL_IN,
   output logic SDA_OUT,
   output logic SDA_OE_OUT,
   output logic SCL_OUT,
   output logic SCL_OE_OUT,
   output logic BUS_COLLISION_FLAG_OUT,
   output logic BUFFER_FULL_STATUS_OUT,
   output logic SERIAL_IRQ_FLAG_OUT,
   output logic ACK_STATUS_OUT,
   output logic START_BUSY_OUT,
   output logic RSTART_BUSY_OUT,
   output logic STOP_BUSY_OUT,
   output logic ACK_BUSY_OUT,
   output logic TX_BUSY_OUT,
   output logic START_SEEN_OUT,
   output logic STOP_SEEN_OUT
);
   i2c_arb_pkg::seq_state_e state_q;
   logic [7:0] shift_q;
   logic [3:0] bit_cnt_q;
   logic ack_bit_q;
   logic tick;
   logic baud_load;
   logic baud_run;
   logic stop_pulse;
   logic start_seen;
   logic stop_seen;
   logic can_take;
   logic start_go;
   logic rstart_go;
   logic stop_go;
   logic ack_go;
   logic tx_go;
   logic coll_event;
   logic done_event;

   initial begin
      if (RELOAD_W < 2 || RELOAD_W > 16)
         $error("RELOAD_W out of supported range");
   end

   // a wider reload than eight bits only lengthens the count
   baud_tick_gen #(.W(RELOAD_W)) u_baud (
      .clk_in(CLK_IN),
      .rst_n_in(RST_N_IN),
      .ce_in(CE_IN),
      .load_in(baud_load),
      .run_in(baud_run),
      .reload_in(RELOAD_IN),
      .tick_out(tick)
   );

   bus_cond_monitor u_mon (
      .clk_in(CLK_IN),
      .rst_n_in(RST_N_IN),
      .ce_in(CE_IN),
      .enable_in(PORT_EN_IN),
      .sda_in(SDA_IN),
      .scl_in(SCL_IN),
      .start_seen_out(start_seen),
      .stop_seen_out(stop_seen),
      .stop_pulse_out(stop_pulse)
   );

   // requests are dropped while collision is pending
   assign can_take = PORT_EN_IN && (state_q == i2c_arb_pkg::ST_IDLE) &&
                     !BUS_COLLISION_FLAG_OUT;
   assign start_go = can_take && START_REQ_IN;
   assign rstart_go = can_take && !START_REQ_IN && RSTART_REQ_IN;
   assign stop_go = can_take && !START_REQ_IN && !RSTART_REQ_IN &&
                    STOP_REQ_IN;
   assign ack_go = can_take && !START_REQ_IN && !RSTART_REQ_IN &&
                   !STOP_REQ_IN && ACK_REQ_IN;
   assign tx_go = can_take && !START_REQ_IN && !RSTART_REQ_IN &&
                  !STOP_REQ_IN && !ACK_REQ_IN && TX_WR_IN;

   always_comb begin
      coll_event = 1'b0;
      case (state_q)
         i2c_arb_pkg::ST_IDLE:
            coll_event = start_go && (!SDA_IN || !SCL_IN);
         i2c_arb_pkg::ST_CHK:
            coll_event = SDA_IN && !SCL_IN;
         i2c_arb_pkg::TX_HIGH:
            coll_event = (bit_cnt_q != i2c_arb_pkg::ACK_SLOT) &&
                         !SDA_OE_OUT && SCL_IN && !SDA_IN;
         i2c_arb_pkg::RS_SCL_WAIT:
            coll_event = SCL_IN && !SDA_IN;
         i2c_arb_pkg::RS_CNT:
            coll_event = !SCL_IN && SDA_IN;
         i2c_arb_pkg::SP_CNT:
            coll_event = !SCL_IN;
         i2c_arb_pkg::SP_SDA_REL:
            coll_event = (!SCL_IN && !SDA_IN) ||
                         (tick && !SDA_IN);
         i2c_arb_pkg::ACK_HIGH:
            coll_event = !SDA_OE_OUT && SCL_IN && !SDA_IN;
         default:
            coll_event = 1'b0;
      endcase
   end

   // load on every accept and tick, and while waiting for a line level
   always_comb begin
      baud_load = tick || start_go || rstart_go || stop_go || ack_go ||
                  tx_go;
      case (state_q)
         i2c_arb_pkg::ST_CHK:
            baud_load = baud_load || !SDA_IN;
         i2c_arb_pkg::SP_SDA_LOW:
            baud_load = baud_load || SDA_IN;
         i2c_arb_pkg::RS_SCL_WAIT,
         i2c_arb_pkg::SP_SCL_WAIT:
            baud_load = 1'b1;
         default:
            baud_load = baud_load;
      endcase
   end

   // stalling on a held-low SCL gives clock stretching in the high phases
   assign baud_run = (state_q != i2c_arb_pkg::ST_IDLE) &&
                     !(((state_q == i2c_arb_pkg::TX_HIGH) ||
                        (state_q == i2c_arb_pkg::ACK_HIGH)) &&
                       !SCL_IN);

   assign done_event = tick && !coll_event &&
                       ((state_q == i2c_arb_pkg::ST_HOLD) ||
                        (state_q == i2c_arb_pkg::RS_HOLD) ||
                        (state_q == i2c_arb_pkg::SP_SDA_REL) ||
                        (state_q == i2c_arb_pkg::ACK_HIGH) ||
                        ((state_q == i2c_arb_pkg::TX_HIGH) &&
                         (bit_cnt_q == i2c_arb_pkg::ACK_SLOT)));

   // sequencer: pin drive and bit position
   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN) begin
         state_q <= i2c_arb_pkg::ST_IDLE;
         SDA_OE_OUT <= 1'b0;
         SCL_OE_OUT <= 1'b0;
         shift_q <= i2c_arb_pkg::SHIFT_RST;
         bit_cnt_q <= i2c_arb_pkg::BIT_CNT_RST;
         ack_bit_q <= 1'b0;
      end else if (CE_IN) begin
         if (!PORT_EN_IN || coll_event) begin
            state_q <= i2c_arb_pkg::ST_IDLE;
            SDA_OE_OUT <= 1'b0;
            SCL_OE_OUT <= 1'b0;
            bit_cnt_q <= i2c_arb_pkg::BIT_CNT_RST;
         end else begin
            case (state_q)
               i2c_arb_pkg::ST_IDLE: begin
                  if (start_go) begin
                     SDA_OE_OUT <= 1'b0;
                     SCL_OE_OUT <= 1'b0;
                     state_q <= i2c_arb_pkg::ST_CHK;
                  end else if (rstart_go) begin
                     SDA_OE_OUT <= 1'b0;
                     state_q <= i2c_arb_pkg::RS_SDA_REL;
                  end else if (stop_go) begin
                     SDA_OE_OUT <= 1'b1;
                     state_q <= i2c_arb_pkg::SP_SDA_LOW;
                  end else if (ack_go) begin
                     SCL_OE_OUT <= 1'b1;
                     SDA_OE_OUT <= !ACK_DATA_IN;
                     ack_bit_q <= ACK_DATA_IN;
                     state_q <= i2c_arb_pkg::ACK_LOW;
                  end else if (tx_go) begin
                     // always from the first bit, never a resumed byte
                     shift_q <= {TX_DATA_IN[6:0], 1'b0};
                     bit_cnt_q <= i2c_arb_pkg::BIT_CNT_RST;
                     SCL_OE_OUT <= 1'b1;
                     SDA_OE_OUT <= !TX_DATA_IN[7];
                     state_q <= i2c_arb_pkg::TX_LOW;
                  end
               end
               i2c_arb_pkg::ST_CHK: begin
                  if (!SDA_IN || tick) begin
                     SDA_OE_OUT <= 1'b1;
                     state_q <= i2c_arb_pkg::ST_HOLD;
                  end
               end
               i2c_arb_pkg::ST_HOLD: begin
                  // scl seen low here is another master's start
                  if (tick) begin
                     SCL_OE_OUT <= 1'b1;
                     state_q <= i2c_arb_pkg::ST_IDLE;
                  end
               end
               i2c_arb_pkg::RS_SDA_REL: begin
                  if (tick) begin
                     SCL_OE_OUT <= 1'b0;
                     state_q <= i2c_arb_pkg::RS_SCL_WAIT;
                  end
               end
               i2c_arb_pkg::RS_SCL_WAIT: begin
                  if (SCL_IN)
                     state_q <= i2c_arb_pkg::RS_CNT;
               end
               i2c_arb_pkg::RS_CNT: begin
                  if (tick) begin
                     SDA_OE_OUT <= 1'b1;
                     state_q <= i2c_arb_pkg::RS_HOLD;
                  end
               end
               i2c_arb_pkg::RS_HOLD: begin
                  if (tick) begin
                     SCL_OE_OUT <= 1'b1;
                     state_q <= i2c_arb_pkg::ST_IDLE;
                  end
               end
               i2c_arb_pkg::SP_SDA_LOW: begin
                  if (tick) begin
                     SCL_OE_OUT <= 1'b0;
                     state_q <= i2c_arb_pkg::SP_SCL_WAIT;
                  end
               end
               i2c_arb_pkg::SP_SCL_WAIT: begin
                  if (SCL_IN)
                     state_q <= i2c_arb_pkg::SP_CNT;
               end
               i2c_arb_pkg::SP_CNT: begin
                  if (tick) begin
                     SDA_OE_OUT <= 1'b0;
                     state_q <= i2c_arb_pkg::SP_SDA_REL;
                  end
               end
               i2c_arb_pkg::SP_SDA_REL: begin
                  if (tick)
                     state_q <= i2c_arb_pkg::ST_IDLE;
               end
               i2c_arb_pkg::TX_LOW: begin
                  if (tick) begin
                     SCL_OE_OUT <= 1'b0;
                     state_q <= i2c_arb_pkg::TX_HIGH;
                  end
               end
               i2c_arb_pkg::TX_HIGH: begin
                  if (tick) begin
                     SCL_OE_OUT <= 1'b1;
                     if (bit_cnt_q == i2c_arb_pkg::ACK_SLOT) begin
                        SDA_OE_OUT <= 1'b0;
                        state_q <= i2c_arb_pkg::ST_IDLE;
                     end else begin
                        // data moves with the falling scl edge
                        bit_cnt_q <= bit_cnt_q + 1'b1;
                        SDA_OE_OUT <= (bit_cnt_q != i2c_arb_pkg::LAST_DATA_BIT)
                                      && !shift_q[7];
                        shift_q <= {shift_q[6:0], 1'b0};
                        state_q <= i2c_arb_pkg::TX_LOW;
                     end
                  end
               end
               i2c_arb_pkg::ACK_LOW: begin
                  if (tick) begin
                     SCL_OE_OUT <= 1'b0;
                     state_q <= i2c_arb_pkg::ACK_HIGH;
                  end
               end
               i2c_arb_pkg::ACK_HIGH: begin
                  if (tick) begin
                     SCL_OE_OUT <= 1'b1;
                     SDA_OE_OUT <= 1'b0;
                     state_q <= i2c_arb_pkg::ST_IDLE;
                  end
               end
               default: begin
                  state_q <= i2c_arb_pkg::ST_IDLE;
                  SDA_OE_OUT <= 1'b0;
                  SCL_OE_OUT <= 1'b0;
               end
            endcase
         end
      end
   end

   // self-clearing busy bits; collision clears them all
   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN) begin
         START_BUSY_OUT <= 1'b0;
         RSTART_BUSY_OUT <= 1'b0;
         STOP_BUSY_OUT <= 1'b0;
         ACK_BUSY_OUT <= 1'b0;
         TX_BUSY_OUT <= 1'b0;
      end else if (CE_IN) begin
         if (!PORT_EN_IN || coll_event || done_event) begin
            START_BUSY_OUT <= 1'b0;
            RSTART_BUSY_OUT <= 1'b0;
            STOP_BUSY_OUT <= 1'b0;
            ACK_BUSY_OUT <= 1'b0;
            TX_BUSY_OUT <= 1'b0;
         end else begin
            START_BUSY_OUT <= START_BUSY_OUT || start_go;
            RSTART_BUSY_OUT <= RSTART_BUSY_OUT || rstart_go;
            STOP_BUSY_OUT <= STOP_BUSY_OUT || stop_go;
            ACK_BUSY_OUT <= ACK_BUSY_OUT || ack_go;
            TX_BUSY_OUT <= TX_BUSY_OUT || tx_go;
         end
      end
   end

   // status flags; a hardware set wins over a same-cycle clear
   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN) begin
         BUS_COLLISION_FLAG_OUT <= 1'b0;
         SERIAL_IRQ_FLAG_OUT <= 1'b0;
         BUFFER_FULL_STATUS_OUT <= 1'b0;
         ACK_STATUS_OUT <= 1'b0;
      end else if (CE_IN) begin
         if (coll_event && PORT_EN_IN)
            BUS_COLLISION_FLAG_OUT <= 1'b1;
         else if (COLL_CLR_IN)
            BUS_COLLISION_FLAG_OUT <= 1'b0;
         if (done_event ||
             (stop_pulse && BUS_COLLISION_FLAG_OUT))
            SERIAL_IRQ_FLAG_OUT <= 1'b1;
         else if (IRQ_CLR_IN)
            SERIAL_IRQ_FLAG_OUT <= 1'b0;
         if (tx_go)
            BUFFER_FULL_STATUS_OUT <= 1'b1;
         else if (!PORT_EN_IN || coll_event ||
                  (tick && state_q == i2c_arb_pkg::TX_HIGH &&
                   bit_cnt_q == i2c_arb_pkg::LAST_DATA_BIT))
            BUFFER_FULL_STATUS_OUT <= 1'b0;
         if (done_event && state_q == i2c_arb_pkg::TX_HIGH)
            ACK_STATUS_OUT <= SDA_IN;
      end
   end

   // open-drain data is always low; only the enables move
   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN) begin
         SDA_OUT <= 1'b0;
         SCL_OUT <= 1'b0;
         START_SEEN_OUT <= 1'b0;
         STOP_SEEN_OUT <= 1'b0;
      end else if (CE_IN) begin
         SDA_OUT <= 1'b0;
         SCL_OUT <= 1'b0;
         START_SEEN_OUT <= start_seen && PORT_EN_IN;
         STOP_SEEN_OUT <= stop_seen && PORT_EN_IN;
      end
   end
endmodule

/* design/i2c_arb_pkg.sv */
// Purpose: shared constants and state codes for the two-wire master
// Assumes: one clock, synchronous active-low reset
// Notes: bit index 8 of a byte transfer is the acknowledge slot
package i2c_arb_pkg;
   localparam int RELOAD_W = 8;
   localparam int MIN_RELOAD = 3;
   localparam logic [3:0] ACK_SLOT = 4'h8;
   localparam logic [3:0] LAST_DATA_BIT = 4'h7;
   localparam logic [7:0] SHIFT_RST = 8'h00;
   localparam logic [3:0] BIT_CNT_RST = 4'h0;

   typedef enum logic [3:0] {
      ST_IDLE     = 4'b0000,
      ST_CHK      = 4'b0001,
      ST_HOLD     = 4'b0010,
      RS_SDA_REL  = 4'b0011,
      RS_SCL_WAIT = 4'b0100,
      RS_CNT      = 4'b0101,
      RS_HOLD     = 4'b0110,
      SP_SDA_LOW  = 4'b0111,
      SP_SCL_WAIT = 4'b1000,
      SP_CNT      = 4'b1001,
      SP_SDA_REL  = 4'b1010,
      TX_LOW      = 4'b1011,
      TX_HIGH     = 4'b1100,
      ACK_LOW     = 4'b1101,
      ACK_HIGH    = 4'b1110
   } seq_state_e;
endpackage

/* design/baud_tick_gen.sv */
// Purpose: reloadable down counter timing each half of a serial clock
// Assumes: load wins over run; counter steps once every two clocks
// Notes: one tick every 2*(reload+1) clocks, so scl = fclk/(4*(reload+1))
`timescale 1ns/1ps
module baud_tick_gen #(
   parameter int W = i2c_arb_pkg::RELOAD_W
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic ce_in,
   input wire logic load_in,
   input wire logic run_in,
   input wire logic [W-1:0] reload_in,
   output logic tick_out
);
   logic [W-1:0] cnt_q;
   logic half_q;

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         cnt_q <= '0;
         half_q <= 1'b0;
         tick_out <= 1'b0;
      end else if (ce_in) begin
         tick_out <= 1'b0;
         if (load_in) begin
            cnt_q <= reload_in;
            // preset phase: the registered tick costs one clock
            half_q <= 1'b1;
         end else if (run_in) begin
            half_q <= ~half_q;
            if (half_q) begin
               if (cnt_q == '0) begin
                  tick_out <= 1'b1;
                  cnt_q <= reload_in;
               end else begin
                  cnt_q <= cnt_q - 1'b1;
               end
            end
         end
      end
   end
endmodule

/* design/bus_cond_monitor.sv */
// Purpose: watch the shared lines for start and stop conditions
// Assumes: line inputs already synchronous to the clock
// Notes: seen flags are cleared while the port is disabled
`timescale 1ns/1ps
module bus_cond_monitor (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic ce_in,
   input wire logic enable_in,
   input wire logic sda_in,
   input wire logic scl_in,
   output logic start_seen_out,
   output logic stop_seen_out,
   output logic stop_pulse_out
);
   logic sda_prev_q;
   logic scl_prev_q;
   logic start_det;
   logic stop_det;

   assign start_det = scl_in && scl_prev_q && sda_prev_q && !sda_in;
   assign stop_det = scl_in && scl_prev_q && !sda_prev_q && sda_in;

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         sda_prev_q <= 1'b1;
         scl_prev_q <= 1'b1;
      end else if (ce_in) begin
         sda_prev_q <= sda_in;
         scl_prev_q <= scl_in;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         start_seen_out <= 1'b0;
         stop_seen_out <= 1'b0;
         stop_pulse_out <= 1'b0;
      end else if (ce_in) begin
         stop_pulse_out <= enable_in && stop_det;
         if (!enable_in) begin
            start_seen_out <= 1'b0;
            stop_seen_out <= 1'b0;
         end else if (start_det) begin
            start_seen_out <= 1'b1;
            stop_seen_out <= 1'b0;
         end else if (stop_det) begin
            start_seen_out <= 1'b0;
            stop_seen_out <= 1'b1;
         end
      end
   end
endmodule

/* tb/i2c_arb_properties.sv */
// Purpose: port checks for the arbitrating two-wire master
// Assumes: one clock, synchronous active-low reset
// Notes: bound to the top module, sees its ports only
`timescale 1ns/1ps
module i2c_arb_checker (
   input wire logic CLK_IN,
   input wire logic RST_N_IN,
   input wire logic CE_IN,
   input wire logic PORT_EN_IN,
   input wire logic START_REQ_IN,
   input wire logic TX_WR_IN,
   input wire logic [7:0] TX_DATA_IN,
   input wire logic COLL_CLR_IN,
   input wire logic SDA_IN,
   input wire logic SCL_IN,
   input wire logic SDA_OE_OUT,
   input wire logic SCL_OE_OUT,
   input wire logic BUS_COLLISION_FLAG_OUT,
   input wire logic BUFFER_FULL_STATUS_OUT,
   input wire logic SERIAL_IRQ_FLAG_OUT,
   input wire logic START_BUSY_OUT,
   input wire logic RSTART_BUSY_OUT,
   input wire logic STOP_BUSY_OUT,
   input wire logic ACK_BUSY_OUT,
   input wire logic TX_BUSY_OUT,
   input wire logic START_SEEN_OUT,
   input wire logic STOP_SEEN_OUT
);
   logic idle;
   logic take;
   assign idle = !(START_BUSY_OUT | RSTART_BUSY_OUT | STOP_BUSY_OUT |
      ACK_BUSY_OUT | TX_BUSY_OUT);
   assign take = CE_IN && PORT_EN_IN && idle && !BUS_COLLISION_FLAG_OUT;
   default clocking dc @(posedge CLK_IN);
   endclocking
   default disable iff (!RST_N_IN);
   a_coll_release: assert property ($rose(BUS_COLLISION_FLAG_OUT) |->
      !SDA_OE_OUT && !SCL_OE_OUT && !BUFFER_FULL_STATUS_OUT && idle)
      else $error("collision left lines or status held");
   a_coll_sticky: assert property (BUS_COLLISION_FLAG_OUT &&
      !COLL_CLR_IN |=> BUS_COLLISION_FLAG_OUT)
      else $error("collision flag dropped without clear");
   a_req_refused: assert property (BUS_COLLISION_FLAG_OUT &&
      START_REQ_IN |=> !START_BUSY_OUT)
      else $error("start taken while collision flag set");
   a_start_line_low: assert property (take && START_REQ_IN &&
      !(SDA_IN && SCL_IN) |=> BUS_COLLISION_FLAG_OUT)
      else $error("start on a low line not flagged");
   a_start_scl_coll: assert property (START_BUSY_OUT && CE_IN &&
      !SDA_OE_OUT && SDA_IN && !SCL_IN |-> ##[1:3] BUS_COLLISION_FLAG_OUT)
      else $error("clock low during start count not flagged");
   a_start_early_sda: assert property (START_BUSY_OUT && CE_IN &&
      !SDA_IN && SCL_IN && !BUS_COLLISION_FLAG_OUT |-> ##[0:2] SDA_OE_OUT)
      else $error("data not pulled early during start");
   a_tx_first_bit: assert property (take && TX_WR_IN &&
      !START_REQ_IN |=> SCL_OE_OUT && BUFFER_FULL_STATUS_OUT &&
      (SDA_OE_OUT != $past(TX_DATA_IN[7])))
      else $error("byte did not begin at its first bit");
   a_seen_cleared: assert property (!PORT_EN_IN && CE_IN |=>
      !START_SEEN_OUT && !STOP_SEEN_OUT)
      else $error("bus seen flags kept while disabled");
   a_stop_irq: assert property (BUS_COLLISION_FLAG_OUT &&
      $rose(STOP_SEEN_OUT) |-> ##[0:2] SERIAL_IRQ_FLAG_OUT)
      else $error("bus stop after collision gave no irq");
   a_idle_lines_hold: assert property (idle && $past(idle) &&
      PORT_EN_IN && !BUS_COLLISION_FLAG_OUT |-> $stable(SCL_OE_OUT))
      else $error("clock line moved while idle");
   c_start_done: cover property ($fell(START_BUSY_OUT) &&
      !BUS_COLLISION_FLAG_OUT);
   c_collision: cover property ($rose(BUS_COLLISION_FLAG_OUT));
   c_byte_done: cover property ($fell(TX_BUSY_OUT) && !BUS_COLLISION_FLAG_OUT);
endmodule

bind i2c_master_arbitration_brg i2c_arb_checker i_chk (
   .CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN), .CE_IN(CE_IN),
   .PORT_EN_IN(PORT_EN_IN), .START_REQ_IN(START_REQ_IN),
   .TX_WR_IN(TX_WR_IN), .TX_DATA_IN(TX_DATA_IN), .COLL_CLR_IN(COLL_CLR_IN),
   .SDA_IN(SDA_IN), .SCL_IN(SCL_IN), .SDA_OE_OUT(SDA_OE_OUT),
   .SCL_OE_OUT(SCL_OE_OUT), .BUS_COLLISION_FLAG_OUT(BUS_COLLISION_FLAG_OUT),
   .BUFFER_FULL_STATUS_OUT(BUFFER_FULL_STATUS_OUT),
   .SERIAL_IRQ_FLAG_OUT(SERIAL_IRQ_FLAG_OUT),
   .START_BUSY_OUT(START_BUSY_OUT), .RSTART_BUSY_OUT(RSTART_BUSY_OUT),
   .STOP_BUSY_OUT(STOP_BUSY_OUT), .ACK_BUSY_OUT(ACK_BUSY_OUT),
   .TX_BUSY_OUT(TX_BUSY_OUT), .START_SEEN_OUT(START_SEEN_OUT),
   .STOP_SEEN_OUT(STOP_SEEN_OUT));

/* tb/i2c_bus_peer.sv */
// Purpose: another party on the shared two-wire bus
// Assumes: open drain, lines float high when nobody pulls
// Notes: pulls are commanded by the bench, one cycle of register delay
`timescale 1ns/1ps
module i2c_bus_peer (
   input wire logic clk_in,
   input wire logic pull_sda_in,
   input wire logic pull_scl_in,
   output logic sda_oe_out = 1'b0,
   output logic scl_oe_out = 1'b0
);
   // registered so a pull never lands in the edge that samples it
   always_ff @(posedge clk_in) begin
      sda_oe_out <= pull_sda_in;
      scl_oe_out <= pull_scl_in;
   end
endmodule

/* tb/i2c_master_arbitration_brg_tb.sv */
// Purpose: self-checking bench for the arbitrating two-wire master
// Assumes: a peer model shares the open-drain lines
// Notes: requests on a free bus or after our own start, save the collision checks
`timescale 1ns/1ps
module i2c_master_arbitration_brg_tb;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic en = 1'b1;
   logic [7:0] reload = 8'h03;
   logic start_r = 1'b0, rstart_r = 1'b0, stop_r = 1'b0, ack_r = 1'b0;
   logic tx_wr = 1'b0, coll_clr = 1'b0, irq_clr = 1'b0, ack_d = 1'b0;
   logic [7:0] tx_d = 8'h00;
   logic ps = 1'b0, pc = 1'b0;
   logic p_sda, p_scl, sda, scl, sda_oe, scl_oe, coll, bf, irq, ack_st;
   logic sb, rb, pb, ab, tb_b, s_seen, p_seen;
   int bad_count = 0, samples_checked = 0, cyc = 0, n = 0;
   assign sda = !(sda_oe | p_sda);
   assign scl = !(scl_oe | p_scl);
   initial begin
      forever #5 clk = ~clk;
   end
   i2c_master_arbitration_brg #(.RELOAD_W(8)) i_i2c_master_arbitration_brg (
      .CLK_IN(clk), .RST_N_IN(rst_n), .CE_IN(1'b1), .PORT_EN_IN(en),
      .RELOAD_IN(reload), .START_REQ_IN(start_r), .RSTART_REQ_IN(rstart_r),
      .STOP_REQ_IN(stop_r), .ACK_REQ_IN(ack_r), .ACK_DATA_IN(ack_d),
      .TX_WR_IN(tx_wr), .TX_DATA_IN(tx_d), .COLL_CLR_IN(coll_clr),
      .IRQ_CLR_IN(irq_clr), .SDA_IN(sda), .SCL_IN(scl), .SDA_OUT(),
      .SDA_OE_OUT(sda_oe), .SCL_OUT(), .SCL_OE_OUT(scl_oe),
      .BUS_COLLISION_FLAG_OUT(coll), .BUFFER_FULL_STATUS_OUT(bf),
      .SERIAL_IRQ_FLAG_OUT(irq), .ACK_STATUS_OUT(ack_st),
      .START_BUSY_OUT(sb), .RSTART_BUSY_OUT(rb), .STOP_BUSY_OUT(pb),
      .ACK_BUSY_OUT(ab), .TX_BUSY_OUT(tb_b), .START_SEEN_OUT(s_seen),
      .STOP_SEEN_OUT(p_seen));
   i2c_bus_peer i_i2c_bus_peer (.clk_in(clk), .pull_sda_in(ps),
      .pull_scl_in(pc), .sda_oe_out(p_sda), .scl_oe_out(p_scl));
   task automatic wrap_up();
      if (bad_count == 0 && samples_checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic got, input logic exp, input string m);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %0t %s", $time, m);
      end
   endtask
   task automatic cycles(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   // k: 0 start, 1 restart, 2 stop, 3 ack, 4 byte, 5 clear coll, 6 clear irq
   task automatic fire(input int k, input logic [7:0] d);
      @(posedge clk);
      {start_r, rstart_r, stop_r, ack_r, tx_wr, coll_clr, irq_clr} <=
         7'h40 >> k;
      tx_d <= d;
      ack_d <= d[0];
      @(posedge clk);
      {start_r, rstart_r, stop_r, ack_r, tx_wr, coll_clr, irq_clr} <= 7'h00;
      #1;
   endtask
   task automatic peer(input logic a, input logic b);
      @(posedge clk);
      ps <= a;
      pc <= b;
   endtask
   task automatic settle();
      while ((sb | rb | pb | ab | tb_b) && n < 600) begin
         cycles(1);
         n++;
      end
      n = 0;
   endtask
   task automatic span(input logic lv);
      while (scl_oe === lv && n < 99) begin
         cycles(1);
         n++;
      end
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         bad_count++;
         wrap_up();
      end
   end
   initial begin
      cycles(5);
      rst_n <= 1'b1;
      cycles(1);
      chk(s_seen | p_seen | coll, 1'b0, "status not clear at reset");
      fire(0, 8'h00);
      chk(sb, 1'b1, "start not taken");
      settle();
      chk(scl_oe & sda_oe & irq & !coll, 1'b1, "start end state");
      fire(6, 8'h00);
      fire(4, 8'ha5);
      chk(bf & !sda_oe, 1'b1, "byte launch");
      span(1'b1);
      span(1'b0);
      chk(n == 4 * (reload + 1), 1'b1, "rate");
      n = 0;
      settle();
      chk(ack_st & !bf, 1'b1, "byte end");
      fire(2, 8'h00);
      settle();
      cycles(2);
      chk(p_seen & !coll, 1'b1, "stop");
      peer(1'b1, 1'b0);
      cycles(2);
      fire(0, 8'h00);
      chk(coll & !sb, 1'b1, "start on low data");
      fire(0, 8'h00);
      chk(sb, 1'b0, "start taken in collision");
      peer(1'b0, 1'b0);
      fire(5, 8'h00);
      fire(0, 8'h00);
      peer(1'b0, 1'b1);
      cycles(5);
      chk(coll & !sda_oe & !scl_oe & !sb, 1'b1, "clock low");
      peer(1'b0, 1'b0);
      fire(5, 8'h00);
      fire(0, 8'h00);
      peer(1'b1, 1'b0);
      cycles(4);
      chk(sda_oe, 1'b1, "data not pulled early");
      peer(1'b0, 1'b0);
      settle();
      fire(6, 8'h00);
      peer(1'b1, 1'b0);
      fire(4, 8'h3f);
      settle();
      chk(coll & !bf & !sda_oe & !scl_oe, 1'b1, "lost byte");
      peer(1'b0, 1'b0);
      cycles(4);
      chk(irq, 1'b1, "no irq on bus stop");
      fire(5, 8'h00);
      fire(4, 8'h20);
      chk(sda_oe, 1'b1, "byte not from first bit");
      settle();
      fire(2, 8'h00);
      settle();
      fire(0, 8'h00);
      settle();
      peer(1'b1, 1'b0);
      fire(1, 8'h00);
      settle();
      chk(coll & !rb, 1'b1, "restart data low");
      peer(1'b0, 1'b0);
      fire(5, 8'h00);
      fire(0, 8'h00);
      settle();
      fire(3, 8'h00);
      settle();
      fire(1, 8'h00);
      settle();
      chk(scl_oe & sda_oe & !coll, 1'b1, "restart end");
      fire(2, 8'h00);
      settle();
      cycles(2);
      chk(p_seen & !coll, 1'b1, "final stop");
      @(posedge clk);
      en <= 1'b0;
      cycles(2);
      chk(s_seen | p_seen, 1'b0, "seen flags kept");
      wrap_up();
   end
endmodule
